// [core/common_status.v]
`timescale 1ns/1ps
`include "common_status_consts.vh"

// How it works
// - indicator shows green normally, yellow on warning, red on error.
// - internal warning sources (boot, sync, settings, frequency, mode, simulation) give warning.
// - outside warning request is one more warning source.
// - composed warning output high whenever the device is in warning state.
// - error state also drives a dedicated supply-module output.
// - latched indicators clear on panel button, computer, supervisory (if configured), or user input.
// - acknowledge pulse each time the front X key is pressed.
// - four independent control groups, each with its own local/remote state.
// - per-group local or remote request sets that group's state.
// - each group drives local and remote indication outputs.
// - enable zero ignores outside requests; touch-screen or command-register toggle only.
// - constant low and constant high outputs.
module common_status (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        booting_operable,
  input  wire        time_sync_missing,
  input  wire        setting_mismatch,
  input  wire        freq_source_missing,
  input  wire        mode_not_normal,
  input  wire        simulation_mode,
  input  wire        internal_error,
  input  wire        outside_warning_request,
  input  wire        indicator_clear_request,
  input  wire        panel_clear_button,
  input  wire        x_key,
  input  wire        indicator_latch_set,
  input  wire        outside_local_request_g1,
  input  wire        outside_remote_request_g1,
  input  wire        outside_local_request_g2,
  input  wire        outside_remote_request_g2,
  input  wire        outside_local_request_g3,
  input  wire        outside_remote_request_g3,
  input  wire        outside_local_request_g4,
  input  wire        outside_remote_request_g4,
  input  wire [3:0]  touch_toggle,
  output reg  [1:0]  device_indicator,
  output reg         composed_warning,
  output reg         supply_error_out,
  output reg         indicator_latch,
  output reg         indicator_clear_pulse,
  output reg         acknowledge_key_pulse,
  output reg         group1_local_ind,
  output reg         group1_remote_ind,
  output reg         group2_local_ind,
  output reg         group2_remote_ind,
  output reg         group3_local_ind,
  output reg         group3_remote_ind,
  output reg         group4_local_ind,
  output reg         group4_remote_ind,
  output reg         constant_low,
  output reg         constant_high,
  output reg         irq
);

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg  [2:0] control_q;
  reg  [6:0] warn_src_q;
  reg  [3:0] irq_status_q;
  reg  [3:0] irq_mask_q;
  reg        x_key_q;
  reg        pc_clear_q;
  reg        scada_clear_q;
  reg  [3:0] sw_toggle_q;

  wire       setup_wr;
  wire       access;
  wire       outside_locrem_enable;
  wire [3:0] local_req;
  wire [3:0] remote_req;
  wire [3:0] grp_local;
  wire [3:0] grp_changed;
  wire [3:0] toggle_any;
  wire       warn_now;
  wire       err_now;
  wire       clear_now;
  wire [3:0] irq_events;
  wire [4:0] status_word;
  reg        addr_ok;
  reg [31:0] rdata_d;

  assign access   = psel & penable;
  assign setup_wr = access & pwrite;
  assign outside_locrem_enable = control_q[`CTL_LOCREM_EN_BIT];

  // ----------------------------------------
  // warning, error, indicator clear
  // ----------------------------------------
  assign warn_now = booting_operable | time_sync_missing | setting_mismatch |
                    freq_source_missing | mode_not_normal | simulation_mode |
                    (|warn_src_q) | outside_warning_request;
  assign err_now  = internal_error | control_q[`CTL_ERROR_BIT];
  assign clear_now = panel_clear_button | pc_clear_q |
                     (scada_clear_q & control_q[`CTL_SCADA_CFG_BIT]) | indicator_clear_request;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_indicator      <= `IND_GREEN;
      composed_warning      <= 1'b0;
      supply_error_out      <= 1'b0;
      indicator_latch       <= 1'b0;
      indicator_clear_pulse <= 1'b0;
      acknowledge_key_pulse <= 1'b0;
      x_key_q               <= 1'b0;
      constant_low          <= 1'b0;
      constant_high         <= 1'b1;
    end else begin
      if (err_now) begin
        device_indicator <= `IND_RED;
      end else if (warn_now) begin
        device_indicator <= `IND_YELLOW;
      end else begin
        device_indicator <= `IND_GREEN;
      end
      composed_warning      <= warn_now;
      supply_error_out      <= err_now;
      if (indicator_latch_set) begin
        indicator_latch <= 1'b1;
      end else if (clear_now) begin
        indicator_latch <= 1'b0;
      end
      indicator_clear_pulse <= clear_now;
      x_key_q               <= x_key;
      acknowledge_key_pulse <= x_key & ~x_key_q;
      constant_low          <= 1'b0;
      constant_high         <= 1'b1;
    end
  end

  // ----------------------------------------
  // control groups
  // ----------------------------------------
  assign local_req  = {outside_local_request_g4, outside_local_request_g3,
                       outside_local_request_g2, outside_local_request_g1};
  assign remote_req = {outside_remote_request_g4, outside_remote_request_g3,
                       outside_remote_request_g2, outside_remote_request_g1};
  assign toggle_any = touch_toggle | sw_toggle_q;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      locrem_group u_group (
        .pclk       (pclk),
        .presetn    (presetn),
        .ext_enable (outside_locrem_enable),
        .local_req  (local_req[g]),
        .remote_req (remote_req[g]),
        .toggle     (toggle_any[g]),
        .is_local_q (grp_local[g]),
        .changed_q  (grp_changed[g])
      );
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group1_local_ind  <= 1'b0;
      group1_remote_ind <= 1'b0;
      group2_local_ind  <= 1'b0;
      group2_remote_ind <= 1'b0;
      group3_local_ind  <= 1'b0;
      group3_remote_ind <= 1'b0;
      group4_local_ind  <= 1'b0;
      group4_remote_ind <= 1'b0;
    end else begin
      group1_local_ind  <= grp_local[0];
      group1_remote_ind <= ~grp_local[0];
      group2_local_ind  <= grp_local[1];
      group2_remote_ind <= ~grp_local[1];
      group3_local_ind  <= grp_local[2];
      group3_remote_ind <= ~grp_local[2];
      group4_local_ind  <= grp_local[3];
      group4_remote_ind <= ~grp_local[3];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign irq_events = {(|grp_changed), clear_now, err_now, warn_now};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 4'h0;
      irq          <= 1'b0;
    end else begin
      // set wins over write-one-to-clear
      if (setup_wr && paddr == `ADDR_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q & ~pwdata[3:0]) | irq_events;
      end else begin
        irq_status_q <= irq_status_q | irq_events;
      end
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign status_word = {indicator_latch, supply_error_out, composed_warning, device_indicator};

  always @* begin
    addr_ok = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `ADDR_CONTROL:      rdata_d = {29'h0, control_q};
      `ADDR_WARN_SOURCES: rdata_d = {25'h0, warn_src_q};
      `ADDR_STATUS:       rdata_d = {27'h0, status_word};
      `ADDR_IRQ_STATUS:   rdata_d = {28'h0, irq_status_q};
      `ADDR_IRQ_MASK:     rdata_d = {28'h0, irq_mask_q};
      `ADDR_GROUP_STATE:  rdata_d = {28'h0, grp_local};
      `ADDR_COMMANDS:     rdata_d = 32'h0000_0000;
      default:            addr_ok = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q     <= `RST_CONTROL;
      warn_src_q    <= `RST_WARN_SOURCES;
      irq_mask_q    <= `RST_IRQ_MASK;
      pc_clear_q    <= 1'b0;
      scada_clear_q <= 1'b0;
      sw_toggle_q   <= 4'h0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else begin
      pc_clear_q    <= 1'b0;
      scada_clear_q <= 1'b0;
      sw_toggle_q   <= 4'h0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= ~addr_ok;
        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      end
      if (setup_wr && pready && addr_ok) begin
        case (paddr)
          `ADDR_CONTROL:      control_q  <= pwdata[2:0];
          `ADDR_WARN_SOURCES: warn_src_q <= pwdata[6:0];
          `ADDR_IRQ_MASK:     irq_mask_q <= pwdata[3:0];
          `ADDR_COMMANDS: begin
            pc_clear_q    <= pwdata[`CMD_PC_CLEAR_BIT];
            scada_clear_q <= pwdata[`CMD_SCADA_CLEAR_BIT];
            sw_toggle_q   <= pwdata[`CMD_TOGGLE_LSB+3:`CMD_TOGGLE_LSB];
          end
          default: ;
        endcase
      end
    end
  end

endmodule // common_status

// [core/common_status_consts.vh]
`ifndef COMMON_STATUS_CONSTS_VH
`define COMMON_STATUS_CONSTS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADDR_CONTROL        12'h000
`define ADDR_WARN_SOURCES   12'h004
`define ADDR_STATUS         12'h008
`define ADDR_IRQ_STATUS     12'h00c
`define ADDR_IRQ_MASK       12'h010
`define ADDR_GROUP_STATE    12'h014
`define ADDR_COMMANDS       12'h018

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTL_LOCREM_EN_BIT   0
`define CTL_SCADA_CFG_BIT   1
`define CTL_ERROR_BIT       2

// ----------------------------------------
// command register fields (write-only pulses)
// ----------------------------------------
`define CMD_PC_CLEAR_BIT    0
`define CMD_SCADA_CLEAR_BIT 1
`define CMD_TOGGLE_LSB      4

// ----------------------------------------
// status register fields
// ----------------------------------------
`define ST_IND_LSB          0
`define ST_WARN_BIT         2
`define ST_ERROR_BIT        3
`define ST_LATCH_BIT        4

// ----------------------------------------
// indicator colour codes
// ----------------------------------------
`define IND_GREEN           2'h0
`define IND_YELLOW          2'h1
`define IND_RED             2'h2

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define IRQ_WARN_BIT        0
`define IRQ_ERROR_BIT       1
`define IRQ_CLEAR_BIT       2
`define IRQ_GROUP_BIT       3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CONTROL         3'h0
`define RST_WARN_SOURCES    7'h00
`define RST_IRQ_MASK        4'h0
`define RST_GROUP_LOCAL     1'b1

`endif

// [core/locrem_group.v]
`timescale 1ns/1ps
`include "common_status_consts.vh"

// one local/remote control group
module locrem_group (
  input  wire pclk,
  input  wire presetn,
  input  wire ext_enable,
  input  wire local_req,
  input  wire remote_req,
  input  wire toggle,
  output reg  is_local_q,
  output reg  changed_q
);

  reg is_local_d;

  always @* begin
    is_local_d = is_local_q;
    if (toggle) begin
      is_local_d = ~is_local_q;
    end else if (ext_enable && (local_req != remote_req)) begin
      is_local_d = local_req;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_local_q <= `RST_GROUP_LOCAL;
      changed_q  <= 1'b0;
    end else begin
      is_local_q <= is_local_d;
      changed_q  <= (is_local_d != is_local_q);
    end
  end

endmodule // locrem_group

// [tb/common_status_chk.sv]
`timescale 1ns/1ps
module common_status_chk (
  input wire       pclk,
  input wire       presetn,
  input wire       internal_error,
  input wire       outside_warning_request,
  input wire       indicator_clear_request,
  input wire       panel_clear_button,
  input wire       x_key,
  input wire       outside_local_request_g1,
  input wire       outside_remote_request_g1,
  input wire [3:0] touch_toggle,
  input wire [1:0] device_indicator,
  input wire       composed_warning,
  input wire       supply_error_out,
  input wire       indicator_clear_pulse,
  input wire       acknowledge_key_pulse,
  input wire       group1_local_ind,
  input wire       group1_remote_ind,
  input wire       constant_low,
  input wire       constant_high
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ack_once;
    acknowledge_key_pulse ##1 !acknowledge_key_pulse;
  endsequence
  property p_ack;
    $rose(x_key) |=> s_ack_once;
  endproperty
  property p_ack_src;
    acknowledge_key_pulse && $past(presetn, 2) |-> $past(x_key) && !$past(x_key, 2);
  endproperty
  property p_warn;
    outside_warning_request |=> composed_warning;
  endproperty
  property p_red;
    internal_error |=> device_indicator == 2'h2 && supply_error_out;
  endproperty
  property p_yel;
    composed_warning && !supply_error_out |-> device_indicator == 2'h1;
  endproperty
  property p_supply;
    supply_error_out == (device_indicator == 2'h2);
  endproperty
  property p_clr;
    indicator_clear_request || panel_clear_button |=> indicator_clear_pulse;
  endproperty
  property p_const;
    $past(presetn) |-> !constant_low && constant_high;
  endproperty
  property p_ind;
    $past(presetn) |-> group1_local_ind != group1_remote_ind;
  endproperty
  property p_hold;
    $past(presetn, 2) && $changed(group1_local_ind) |-> $past(outside_local_request_g1, 2) ||
      $past(outside_remote_request_g1, 2) || $past(touch_toggle[0], 2);
  endproperty
  a_ack: assert property (p_ack) else $error("ack pulse wrong");
  a_ack_src: assert property (p_ack_src) else $error("ack without key");
  a_warn: assert property (p_warn) else $error("warning not composed");
  a_red: assert property (p_red) else $error("error not red");
  a_yel: assert property (p_yel) else $error("warning not yellow");
  a_supply: assert property (p_supply) else $error("supply output wrong");
  a_clr: assert property (p_clr) else $error("clear pulse missing");
  a_const: assert property (p_const) else $error("constants wrong");
  a_ind: assert property (p_ind) else $error("indications not complementary");
  a_hold: assert property (p_hold) else $error("group changed alone");
endmodule // common_status_chk

bind common_status common_status_chk u_chk (.*);

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "common_status_consts.vh"
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  src = 7'h00;
  logic        indicator_latch_set = 1'b0;
  logic [15:0] ctl;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, irq, constant_low, constant_high;
  logic [1:0]  device_indicator;
  logic        composed_warning, supply_error_out, indicator_latch, indicator_clear_pulse;
  logic        acknowledge_key_pulse, x_key, panel_clear_button, indicator_clear_request;
  logic        group1_local_ind, group1_remote_ind, group2_local_ind, group2_remote_ind;
  logic        group3_local_ind, group3_remote_ind, group4_local_ind, group4_remote_ind;
  logic        booting_operable, time_sync_missing, setting_mismatch, freq_source_missing;
  logic        mode_not_normal, simulation_mode, internal_error, outside_warning_request;
  logic        outside_local_request_g1, outside_local_request_g2;
  logic        outside_local_request_g3, outside_local_request_g4;
  logic        outside_remote_request_g1, outside_remote_request_g2;
  logic        outside_remote_request_g3, outside_remote_request_g4;
  logic [3:0]  touch_toggle;
  int          err_total = 0;
  int          cmp_count = 0;
  wire  [7:0]  grp = {group4_remote_ind, group3_remote_ind, group2_remote_ind, group1_remote_ind,
                      group4_local_ind, group3_local_ind, group2_local_ind, group1_local_ind};

  assign {booting_operable, time_sync_missing, setting_mismatch, freq_source_missing,
          mode_not_normal, simulation_mode, internal_error} = src;
  assign {x_key, panel_clear_button, indicator_clear_request, outside_warning_request} = ctl[15:12];
  assign touch_toggle = ctl[11:8];
  assign {outside_remote_request_g4, outside_remote_request_g3, outside_remote_request_g2,
          outside_remote_request_g1} = ctl[7:4];
  assign {outside_local_request_g4, outside_local_request_g3, outside_local_request_g2,
          outside_local_request_g1} = ctl[3:0];

  common_status DUT (.*);
  user_side_model u_user (.pclk(pclk), .ctl(ctl));

  always #12.5 pclk = ~pclk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    apb(1'b0, `ADDR_CONTROL, 32'h0);
    chk("control", `RST_CONTROL, rd);
    apb(1'b0, `ADDR_IRQ_MASK, 32'h0);
    chk("irq_mask", `RST_IRQ_MASK, rd);
    apb(1'b0, `ADDR_GROUP_STATE, 32'h0);
    chk("group_state", 32'hf, rd);
    chk("groups", 8'h0f, grp);
    chk("consts", 2'h2, {constant_high, constant_low});
    $display("reset test done");
  endtask
  task t_warn;
    for (int i = 1; i < 7; i++) begin
      @(posedge pclk) src <= 7'h01 << i;
      tick(1);
      chk("warn_src", 3'h5, {composed_warning, device_indicator});
    end
    @(posedge pclk) src <= 7'h41;
    tick(1);
    chk("red", 3'h6, {supply_error_out, device_indicator});
    @(posedge pclk) src <= 7'h00;
    u_user.send(16'h1000, 1);
    #1;
    chk("ext_warn", 3'h5, {composed_warning, device_indicator});
    tick(1);
    chk("green", 3'h0, {composed_warning, device_indicator});
    $display("warning test done");
  endtask
  task t_clear;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk) indicator_latch_set <= 1'b1;
      @(posedge pclk) indicator_latch_set <= 1'b0;
      if (i > 2) apb(1'b1, `ADDR_CONTROL, {30'h0, i == 4, 1'b0});
      case (i)
        0: u_user.send(16'h4000, 1);
        1: u_user.send(16'h2000, 1);
        2: apb(1'b1, `ADDR_COMMANDS, 32'h1);
        default: apb(1'b1, `ADDR_COMMANDS, 32'h2);
      endcase
      tick(1);
      chk("latch", i == 3, indicator_latch);
    end
    $display("clear test done");
  endtask
  task t_ack;
    int c;
    c = 0;
    fork
      begin
        u_user.send(16'h8000, 3);
        u_user.send(16'h8000, 2);
      end
      repeat (12) begin
        tick(1);
        c += (acknowledge_key_pulse === 1'b1);
      end
    join
    chk("ack_count", 2, c);
    $display("ack test done");
  endtask
  task t_group;
    apb(1'b1, `ADDR_CONTROL, 32'h0);
    u_user.send(16'h00f0, 1);
    u_user.send(16'h0400, 1);
    tick(1);
    chk("groups_off", 8'h4b, grp);
    apb(1'b1, `ADDR_CONTROL, 32'h1);
    u_user.send(16'h00a1, 1);
    tick(1);
    chk("groups_on", 8'he1, grp);
    u_user.send(16'h05c8, 1);
    tick(1);
    chk("groups_mix", 8'hb4, grp);
    apb(1'b0, `ADDR_GROUP_STATE, 32'h0);
    chk("group_state", 32'h4, rd);
    $display("group test done");
  endtask
  task t_irq;
    apb(1'b1, `ADDR_IRQ_STATUS, 32'hf);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
    tick(1);
    chk("irq_idle", 0, irq);
    @(posedge pclk) src <= 7'h40;
    @(posedge pclk) src <= 7'h00;
    tick(3);
    chk("irq_set", 1, irq);
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h1);
    tick(1);
    chk("irq_clr", 0, irq);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
    u_user.send(16'h1000, 1);
    tick(3);
    chk("irq_masked", 0, irq);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    chk("irq_status", 1, rd[0]);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 1, {rd[30:0], er});
    $display("irq test done");
  endtask
  task t_regs;
    apb(1'b1, `ADDR_WARN_SOURCES, 32'h1);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status_warn", 32'h05, rd);
    apb(1'b0, `ADDR_WARN_SOURCES, 32'h0);
    chk("warn_src_reg", 32'h01, rd);
    apb(1'b1, `ADDR_CONTROL, 32'h5);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status_err", 32'h0e, rd);
    apb(1'b1, `ADDR_COMMANDS, 32'h20);
    apb(1'b0, `ADDR_GROUP_STATE, 32'h0);
    chk("sw_toggle", 32'h6, rd);
    @(posedge pclk) presetn <= 1'b0;
    tick(2);
    chk("rst_out", 3'h0, {supply_error_out, device_indicator});
    chk("rst_consts", 2'h2, {constant_high, constant_low});
    @(posedge pclk) presetn <= 1'b1;
    tick(1);
    chk("rst_groups", 8'h0f, grp);
    apb(1'b0, `ADDR_CONTROL, 32'h0);
    chk("rst_control", `RST_CONTROL, rd);
    $display("register test done");
  endtask

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_warn;
    t_clear;
    t_ack;
    t_group;
    t_irq;
    t_regs;
    end_sim;
  end
  initial begin
    #50000;
    err_total++;
    end_sim;
  end
endmodule // tb_top

// [tb/user_side_model.sv]
`timescale 1ns/1ps
// bits: 3:0 local, 7:4 remote, 11:8 toggle, 12 warn, 13 clear, 14 panel, 15 x key
module user_side_model (
  input  wire         pclk,
  output logic [15:0] ctl
);
  initial ctl = 16'h0000;
  task send(input logic [15:0] v, input int n);
    @(posedge pclk) ctl <= v;
    repeat (n) @(posedge pclk);
    ctl <= 16'h0000;
  endtask
endmodule // user_side_model
